// ### design/pcc_counter.sv
`include "pcc_consts.svh"
`default_nettype none

module pcc_counter #(
  parameter bit ASYNC_CLEAR = 1'b1,
  parameter bit DECADE = 1'b0
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic COUNT_CLOCK,
  input wire logic MASTER_CLEAR_N,
  input wire logic PARALLEL_LOAD_N,
  input wire logic COUNT_ENABLE_PARALLEL,
  input wire logic COUNT_ENABLE_TRICKLE,
  input wire logic [`PCC_COUNT_W-1:0] PRESET_INPUTS,
  output logic [`PCC_COUNT_W-1:0] COUNT_OUTPUTS,
  output logic RIPPLE_CARRY_OUT,
  output pcc_pkg::pcc_op_t LAST_OP,
  output logic ORDER_WARN
);

  // Terminal value of the selected sequence.
  function automatic logic is_terminal(
    input logic [`PCC_COUNT_W-1:0] value
  );
    logic [`PCC_COUNT_W-1:0] term;
    term = DECADE ? `PCC_TERM_DEC : `PCC_TERM_BIN;
    return value == term;
  endfunction

  // Next value of one counting step.
  function automatic logic [`PCC_COUNT_W-1:0] next_count(
    input logic [`PCC_COUNT_W-1:0] value
  );
    logic [`PCC_COUNT_W-1:0] nxt;
    nxt = value + `PCC_COUNT_STEP;
    // Illegal decade values above nine go straight back to zero, so one
    // step is always enough to rejoin the sequence.
    if (DECADE && (value >= `PCC_TERM_DEC)) begin
      nxt = `PCC_COUNT_RST;
    end
    return nxt;
  endfunction

  pcc_pkg::pcc_ctrl_t ctl;
  pcc_pkg::pcc_watch_t watch;
  pcc_pkg::pcc_watch_t rise;
  pcc_pkg::pcc_watch_t fall;
  pcc_pkg::pcc_state_t st_q;
  pcc_pkg::pcc_state_t st_d;
  logic clear_now;
  logic [`PCC_COUNT_W-1:0] count_vis;
  logic late_enable_drop;
  logic late_load_release;
  logic late_clear_release;

  assign ctl.mclr_n = MASTER_CLEAR_N;
  assign ctl.load_n = PARALLEL_LOAD_N;
  assign ctl.en_par = COUNT_ENABLE_PARALLEL;
  assign ctl.en_trk = COUNT_ENABLE_TRICKLE;
  assign ctl.preset = PRESET_INPUTS;

  assign watch.clk = COUNT_CLOCK;
  assign watch.en_par = COUNT_ENABLE_PARALLEL;
  assign watch.en_trk = COUNT_ENABLE_TRICKLE;
  assign watch.load_n = PARALLEL_LOAD_N;
  assign watch.mclr_n = MASTER_CLEAR_N;

  // The count clock is a pin sampled by the system clock; its rising edge
  // becomes a one-cycle enable, so it must stay at or below half the MCLK rate.
  pcc_edge_track u_edges (
    .clk(MCLK),
    .rst(SYS_RST),
    .level(watch),
    .rise(rise),
    .fall(fall)
  );

  // Clear that acts without waiting for a count clock edge.
  assign clear_now = ASYNC_CLEAR && !ctl.mclr_n;

  // Changes of the driving logic that happen while the count clock is low.
  // They do not alter the count; they are reported for the system to see.
  assign late_enable_drop = (fall.en_par || fall.en_trk) &&
                            !COUNT_CLOCK;
  assign late_load_release = rise.load_n && !COUNT_CLOCK;
  assign late_clear_release = !ASYNC_CLEAR && rise.mclr_n &&
                              !COUNT_CLOCK;

  always_comb begin
    st_d = st_q;
    st_d.warn = late_enable_drop || late_load_release ||
                late_clear_release;
    if (clear_now) begin
      // Held at zero every cycle the clear stays low, edge or not.
      st_d.count = `PCC_COUNT_RST;
      st_d.op = pcc_pkg::PCC_OP_CLEAR;
    end else if (rise.clk) begin
      if (!ctl.mclr_n) begin
        st_d.count = `PCC_COUNT_RST;
        st_d.op = pcc_pkg::PCC_OP_CLEAR;
      end else if (!ctl.load_n) begin
        st_d.count = ctl.preset;
        st_d.op = pcc_pkg::PCC_OP_LOAD;
      end else if (ctl.en_par && ctl.en_trk) begin
        st_d.count = next_count(st_q.count);
        st_d.op = pcc_pkg::PCC_OP_COUNT;
      end else begin
        st_d.op = pcc_pkg::PCC_OP_HOLD;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      st_q.count <= `PCC_COUNT_RST;
      st_q.op <= pcc_pkg::PCC_OP_IDLE;
      st_q.warn <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // The asynchronous clear must be seen on the pins in the same cycle, so
  // the registered count is masked rather than waiting for the next edge.
  assign count_vis = clear_now ? `PCC_COUNT_RST : st_q.count;
  assign COUNT_OUTPUTS = count_vis;

  // Look-ahead carry: a next stage joined here counts on the same edge.
  assign RIPPLE_CARRY_OUT = ctl.en_trk &&
                            is_terminal(count_vis);
  assign LAST_OP = st_q.op;
  assign ORDER_WARN = st_q.warn;

endmodule // pcc_counter

`default_nettype wire

// ### design/pcc_consts.svh
`ifndef PCC_CONSTS_SVH
`define PCC_CONSTS_SVH

// Width of the count and of the preset data.
`define PCC_COUNT_W 4
// Count value after any clear or system reset.
`define PCC_COUNT_RST 4'h0
// Increment applied on each counting step.
`define PCC_COUNT_STEP 4'h1
// Terminal count of the binary sequence.
`define PCC_TERM_BIN 4'hF
// Terminal count of the decade sequence.
`define PCC_TERM_DEC 4'h9
// Number of input pins watched for edges.
`define PCC_WATCH_W 5

`endif

// ### design/pcc_pkg.sv
`include "pcc_consts.svh"
`default_nettype none

package pcc_pkg;

  // Control inputs sampled together on each system clock.
  typedef struct packed {
    logic mclr_n;
    logic load_n;
    logic en_par;
    logic en_trk;
    logic [`PCC_COUNT_W-1:0] preset;
  } pcc_ctrl_t;

  // Last operation taken by the counter.
  typedef enum logic [2:0] {
    PCC_OP_IDLE,
    PCC_OP_CLEAR,
    PCC_OP_LOAD,
    PCC_OP_COUNT,
    PCC_OP_HOLD
  } pcc_op_t;

  // Pins whose edges are tracked, in bit order high to low.
  typedef struct packed {
    logic clk;
    logic en_par;
    logic en_trk;
    logic load_n;
    logic mclr_n;
  } pcc_watch_t;

  // Whole state of the counter.
  typedef struct packed {
    logic [`PCC_COUNT_W-1:0] count;
    pcc_op_t op;
    logic warn;
  } pcc_state_t;

  // Whole state of the edge tracker.
  typedef struct packed {
    logic [`PCC_WATCH_W-1:0] prev;
    logic primed;
  } pcc_edge_state_t;

endpackage

`default_nettype wire

// ### design/pcc_edge_track.sv
`include "pcc_consts.svh"
`default_nettype none

module pcc_edge_track (
  input wire logic clk,
  input wire logic rst,
  input wire pcc_pkg::pcc_watch_t level,
  output pcc_pkg::pcc_watch_t rise,
  output pcc_pkg::pcc_watch_t fall
);

  pcc_pkg::pcc_edge_state_t st_q;
  pcc_pkg::pcc_edge_state_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.prev = level;
    st_d.primed = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // No edge is reported until one sample has been taken, so a pin that is
  // already high when reset is released is not mistaken for a rising edge.
  assign rise = st_q.primed ? (level & ~st_q.prev) : '0;
  assign fall = st_q.primed ? (~level & st_q.prev) : '0;

endmodule // pcc_edge_track

`default_nettype wire

// ### verification/pcc_drv.sv
`default_nettype none
module pcc_drv (
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  output logic cclk
);
  // Stands low outside a burst; every stage would share this clock.
  always_ff @(posedge clk) begin
    cclk <= !rst && run && !cclk;
  end
endmodule // pcc_drv
`default_nettype wire

// ### verification/pcc_counter_props.sv
`default_nettype none
module pcc_counter_props #(
  parameter bit ASYNC_CLEAR = 1'b1,
  parameter bit DECADE = 1'b0
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic COUNT_CLOCK,
  input wire logic MASTER_CLEAR_N,
  input wire logic PARALLEL_LOAD_N,
  input wire logic COUNT_ENABLE_PARALLEL,
  input wire logic COUNT_ENABLE_TRICKLE,
  input wire logic [3:0] PRESET_INPUTS,
  input wire logic [3:0] COUNT_OUTPUTS,
  input wire logic RIPPLE_CARRY_OUT
);
  logic en;
  logic go;
  logic [3:0] term;
  logic [3:0] nxt;
  assign en = COUNT_ENABLE_PARALLEL && COUNT_ENABLE_TRICKLE;
  assign go = MASTER_CLEAR_N && PARALLEL_LOAD_N;
  assign term = DECADE ? 4'h9 : 4'hF;
  // Out-of-sequence decade values fall back to zero in one step.
  assign nxt = (DECADE && COUNT_OUTPUTS >= 4'h9) ? 4'h0
    : COUNT_OUTPUTS + 4'h1;
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  sequence s_rise;
    COUNT_CLOCK && !$past(COUNT_CLOCK);
  endsequence
  a_carry_term: assert property (
    RIPPLE_CARRY_OUT == (COUNT_ENABLE_TRICKLE && COUNT_OUTPUTS == term))
    else $error("carry wrong");
  a_async_zero: assert property (
    ASYNC_CLEAR && !MASTER_CLEAR_N |-> COUNT_OUTPUTS == 4'h0)
    else $error("clear not at once");
  a_edge_only: assert property (
    !COUNT_CLOCK || $past(COUNT_CLOCK) |=>
    !MASTER_CLEAR_N || $stable(COUNT_OUTPUTS)) else $error("moved");
  a_count_step: assert property (
    s_rise ##0 (go && en) |=> COUNT_OUTPUTS == $past(nxt))
    else $error("bad step");
  a_load_copy: assert property (
    s_rise ##0 (MASTER_CLEAR_N && !PARALLEL_LOAD_N) |=>
    COUNT_OUTPUTS == $past(PRESET_INPUTS)) else $error("bad load");
  a_enable_hold: assert property (
    s_rise ##0 (go && !en) |=> $stable(COUNT_OUTPUTS))
    else $error("no hold");
  a_clear_first: assert property (
    s_rise ##0 !MASTER_CLEAR_N |=>
    COUNT_OUTPUTS == 4'h0 && !RIPPLE_CARRY_OUT)
    else $error("no clear");
  // The synchronous variant keeps its carry until the next rising edge.
  a_clear_carry: assert property (
    ASYNC_CLEAR && !MASTER_CLEAR_N |-> !RIPPLE_CARRY_OUT)
    else $error("carry on clear");
endmodule // pcc_counter_props
bind pcc_counter pcc_counter_props #(.ASYNC_CLEAR(ASYNC_CLEAR),
  .DECADE(DECADE)) u_props (.*);
`default_nettype wire

// ### verification/pcc_counter_test.sv
`default_nettype none
module pcc_counter_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, run = 0, cclk, tc;
  logic clr_n = 1, ld_n = 1, ep = 0, et = 0;
  logic [3:0] p = 4'h0, q;
  logic tc2, w1, w2;
  logic [3:0] q2, m2 = 4'h0;
  pcc_pkg::pcc_op_t op1, op2;
  int error_cnt = 0, total_checks = 0;
  always #50 mclk = !mclk;
  pcc_drv u_drv (.clk(mclk), .rst(rst), .run(run), .cclk(cclk));
  pcc_counter DUT (.MCLK(mclk), .SYS_RST(rst), .COUNT_CLOCK(cclk),
    .MASTER_CLEAR_N(clr_n), .PARALLEL_LOAD_N(ld_n),
    .COUNT_ENABLE_PARALLEL(ep), .COUNT_ENABLE_TRICKLE(et),
    .PRESET_INPUTS(p), .COUNT_OUTPUTS(q), .RIPPLE_CARRY_OUT(tc),
    .LAST_OP(op1), .ORDER_WARN(w1));
  // Second stage covers the synchronous clear and the decade sequence.
  pcc_counter #(.ASYNC_CLEAR(1'b0), .DECADE(1'b1)) DUT_SYNC (
    .MCLK(mclk), .SYS_RST(rst), .COUNT_CLOCK(cclk),
    .MASTER_CLEAR_N(clr_n), .PARALLEL_LOAD_N(ld_n),
    .COUNT_ENABLE_PARALLEL(ep), .COUNT_ENABLE_TRICKLE(et),
    .PRESET_INPUTS(p), .COUNT_OUTPUTS(q2), .RIPPLE_CARRY_OUT(tc2),
    .LAST_OP(op2), .ORDER_WARN(w2));
  task chk(input logic [17:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %h exp %h", $time, got, exp);
    end
  endtask
  // Controls change only while the count clock is high.
  task op(input logic c, l, e1, e2, input logic [3:0] d, x);
    pcc_pkg::pcc_op_t eo;
    do begin @(posedge mclk); #1; end while (cclk !== 1'b1);
    {clr_n, ld_n, ep, et, p} = {c, l, e1, e2, d};
    eo = !c ? pcc_pkg::PCC_OP_CLEAR : !l ? pcc_pkg::PCC_OP_LOAD :
      (e1 && e2) ? pcc_pkg::PCC_OP_COUNT : pcc_pkg::PCC_OP_HOLD;
    m2 = !c ? 4'h0 : !l ? d : !(e1 && e2) ? m2 :
      (m2 >= 4'h9) ? 4'h0 : m2 + 4'h1;
    #1;
    if (!c) chk({13'h0, tc, q}, 18'h0);
    @(posedge mclk);
    #1;
    chk({w1, op1, tc, q, w2, op2, tc2, q2}, {1'b0, eo, e2 && x == 4'hF, x,
      1'b0, eo, e2 && m2 == 4'h9, m2});
  endtask
  // Dropping an enable while the count clock is low raises the warning.
  task t_warn;
    do begin @(posedge mclk); #1; end while (cclk !== 1'b0);
    ep = 1'b0;
    @(posedge mclk);
    #1;
    chk({16'h0, w1, w2}, 18'h3);
    @(posedge mclk);
    #1;
    chk({16'h0, w1, w2}, 18'h0);
    $display("warn done");
  endtask
  task t_load;
    op(1, 0, 0, 0, 4'hF, 4'hF);
    op(1, 1, 0, 1, 4'h0, 4'hF);
    op(1, 1, 1, 0, 4'h0, 4'hF);
    $display("load and hold done");
  endtask
  task t_count;
    for (int i = 0; i < 16; i++) begin
      op(1, 1, 1, 1, 4'h0, 4'(i));
    end
    $display("count done");
  endtask
  task t_clear;
    op(1, 0, 1, 1, 4'hA, 4'hA);
    op(0, 0, 1, 1, 4'h5, 4'h0);
    op(1, 1, 1, 1, 4'h0, 4'h1);
    op(0, 1, 1, 1, 4'h0, 4'h0);
    $display("clear done");
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    #1;
    rst = 0;
    run = 1;
    t_load;
    t_count;
    t_clear;
    t_warn;
    wrap_up;
  end
  initial begin
    repeat (400) @(posedge mclk);
    error_cnt++;
    wrap_up;
  end
endmodule // pcc_counter_test
`default_nettype wire
